//--- logic/sera_top.sv
// Purpose: Two-wire EEPROM slave covering reads and acknowledge polling.
// Assumes: The bus master drives the serial clock; pins are asynchronous.
// Notes: Memory is flip-flops; written bytes wait in a FIFO for the write cycle.
`timescale 1ns/100ps
`include "sera_cfg.svh"
module sera_top
  import sera_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // Two-wire bus pins, data line open drain.
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  // Straps and status.
  input  wire logic [2:0] chipSelectInputs,
  output logic            writeBusy
);
  localparam int AW = `SERA_ADDR_W;

  logic          sclMeta_reg;
  logic          sclSync_reg;
  logic          sclLast_reg;
  logic          sdaMeta_reg;
  logic          sdaSync_reg;
  logic          sdaLast_reg;
  logic [2:0]    csMeta_reg;
  logic [2:0]    csSync_reg;
  sera_state_t   state_reg;
  sera_kind_t    kind_reg;
  logic [3:0]    bitCnt_reg;
  logic [7:0]    shift_reg;
  logic          isRead_reg;
  logic          mackSeen_reg;
  logic          sdaOe_reg;
  logic [AW-1:0] addrPtr_reg;
  logic [AW-1:0] wrAddr_reg;
  logic          wrPending_reg;
  logic          drain_reg;
  logic          busy_reg;
  logic [15:0]   timer_reg;
  logic [7:0]    mem_reg [`SERA_DEPTH];

  logic          sclRise;
  logic          sclFall;
  logic          startSeen;
  logic          stopSeen;
  logic          byteDone;
  logic          ctrlMatch;
  logic          ackOk;
  logic          addrTake;
  logic          dataTake;
  logic          loadTx;
  logic [7:0]    rdByte;
  logic          fifoReady;
  logic          fifoValid;
  logic [7:0]    fifoData;
  logic          fifoPop;

  // Two-flop synchronisers; the last-value flops read only the second stage.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sclMeta_reg <= 1'b1;
      sclSync_reg <= 1'b1;
      sclLast_reg <= 1'b1;
      sdaMeta_reg <= 1'b1;
      sdaSync_reg <= 1'b1;
      sdaLast_reg <= 1'b1;
    end else begin
      sclMeta_reg <= sclIn;
      sclSync_reg <= sclMeta_reg;
      sclLast_reg <= sclSync_reg;
      sdaMeta_reg <= sdaIn;
      sdaSync_reg <= sdaMeta_reg;
      sdaLast_reg <= sdaSync_reg;
    end
  end

  // Chip select straps are pins too, so they are synchronised.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      csMeta_reg <= 3'h0;
      csSync_reg <= 3'h0;
    end else begin
      csMeta_reg <= chipSelectInputs;
      csSync_reg <= csMeta_reg;
    end
  end

  // Bus events seen on the system clock.
  assign sclRise   = sclSync_reg && !sclLast_reg;
  assign sclFall   = !sclSync_reg && sclLast_reg;
  assign startSeen = sclSync_reg && sclLast_reg && sdaLast_reg && !sdaSync_reg;
  assign stopSeen  = sclSync_reg && sclLast_reg && !sdaLast_reg && sdaSync_reg;
  assign byteDone  = (state_reg == ST_RECV) && sclFall && (bitCnt_reg == 4'h8);

  // Control byte decode: code and select bits must both match.
  assign ctrlMatch = (shift_reg[`SERA_CODE_MSB:`SERA_CODE_LSB] == `SERA_CTRL_CODE)
                  && (shift_reg[`SERA_SEL_MSB:`SERA_SEL_LSB] == csSync_reg);

  // Acknowledge decision per byte kind; a full FIFO holds back the ack.
  always_comb begin
    case (kind_reg)
      KIND_CTRL: ackOk = ctrlMatch && !busy_reg;
      KIND_ADDR: ackOk = 1'b1;
      KIND_DATA: ackOk = fifoReady;
      default:   ackOk = 1'b0;
    endcase
  end

  assign addrTake = byteDone && (kind_reg == KIND_ADDR);
  assign dataTake = byteDone && (kind_reg == KIND_DATA) && fifoReady;
  assign rdByte   = mem_reg[addrPtr_reg];

  // A byte is fetched when a read starts or the master asks for more.
  assign loadTx = sclFall && (((state_reg == ST_ACK) && (kind_reg == KIND_CTRL) && isRead_reg)
                  || ((state_reg == ST_MACK) && mackSeen_reg));

  // Byte engine: receive, acknowledge, transmit and master acknowledge.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg  <= ST_IDLE;
      kind_reg   <= KIND_CTRL;
      bitCnt_reg <= 4'h0;
      shift_reg  <= 8'h00;
      isRead_reg <= 1'b0;
      sdaOe_reg  <= 1'b0;
    end else if (startSeen) begin
      // Any start, repeated or not, restarts with a control byte.
      state_reg  <= ST_RECV;
      kind_reg   <= KIND_CTRL;
      bitCnt_reg <= 4'h0;
      sdaOe_reg  <= 1'b0;
    end else if (stopSeen) begin
      state_reg <= ST_IDLE;
      sdaOe_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_RECV: begin
          if (sclRise && (bitCnt_reg != 4'h8)) begin
            shift_reg  <= {shift_reg[6:0], sdaSync_reg};
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end else if (byteDone) begin
            // A refused byte leaves the slave deaf until the next start.
            state_reg <= ackOk ? ST_ACK : ST_IDLE;
            sdaOe_reg <= ackOk;
            if (kind_reg == KIND_CTRL) begin
              isRead_reg <= shift_reg[`SERA_RW_BIT];
            end
          end
        end
        ST_ACK: begin
          if (loadTx) begin
            state_reg  <= ST_SEND;
            shift_reg  <= rdByte;
            bitCnt_reg <= 4'h1;
            sdaOe_reg  <= !rdByte[7];
          end else if (sclFall) begin
            state_reg  <= ST_RECV;
            kind_reg   <= (kind_reg == KIND_CTRL) ? KIND_ADDR : KIND_DATA;
            bitCnt_reg <= 4'h0;
            sdaOe_reg  <= 1'b0;
          end
        end
        ST_SEND: begin
          if (sclFall) begin
            if (bitCnt_reg == 4'h8) begin
              // Release for the master's acknowledge bit.
              state_reg <= ST_MACK;
              sdaOe_reg <= 1'b0;
            end else begin
              shift_reg  <= {shift_reg[6:0], 1'b0};
              bitCnt_reg <= bitCnt_reg + 4'h1;
              sdaOe_reg  <= !shift_reg[6];
            end
          end
        end
        ST_MACK: begin
          if (loadTx) begin
            state_reg  <= ST_SEND;
            shift_reg  <= rdByte;
            bitCnt_reg <= 4'h1;
            sdaOe_reg  <= !rdByte[7];
          end else if (sclFall) begin
            // No acknowledge: leave the line high so stop can follow.
            state_reg <= ST_IDLE;
            sdaOe_reg <= 1'b0;
          end
        end
        default: begin
          sdaOe_reg <= 1'b0;
        end
      endcase
    end
  end

  // Master acknowledge is sampled on the rising clock of the ninth bit.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mackSeen_reg <= 1'b0;
    end else if (state_reg != ST_MACK) begin
      mackSeen_reg <= 1'b0;
    end else if (sclRise) begin
      mackSeen_reg <= !sdaSync_reg;
    end
  end

  // Shared address pointer; seven bits give the wrap for free.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      addrPtr_reg <= '0;
      wrAddr_reg  <= '0;
    end else begin
      if (addrTake) begin
        addrPtr_reg <= shift_reg[AW-1:0];
        wrAddr_reg  <= shift_reg[AW-1:0];
      end else if (loadTx) begin
        addrPtr_reg <= addrPtr_reg + 1'b1;
      end else if (dataTake) begin
        // Writes stay inside their sixteen-byte page.
        addrPtr_reg <= {addrPtr_reg[AW-1:4], addrPtr_reg[3:0] + 4'h1};
      end
      if (fifoPop && busy_reg) begin
        wrAddr_reg <= {wrAddr_reg[AW-1:4], wrAddr_reg[3:0] + 4'h1};
      end
    end
  end

  // Pending data is committed by stop, or discarded by a repeated start.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wrPending_reg <= 1'b0;
      drain_reg     <= 1'b0;
    end else begin
      if (dataTake) begin
        wrPending_reg <= 1'b1;
      end else if (startSeen || stopSeen) begin
        wrPending_reg <= 1'b0;
      end
      if (startSeen && wrPending_reg) begin
        drain_reg <= 1'b1;
      end else if (!fifoValid) begin
        drain_reg <= 1'b0;
      end
    end
  end

  // Self-timed write cycle; the timer outlasts draining eight bytes.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg  <= 1'b0;
      timer_reg <= 16'h0000;
    end else if (stopSeen && wrPending_reg) begin
      busy_reg  <= 1'b1;
      timer_reg <= 16'h0000;
    end else if (busy_reg) begin
      if (timer_reg == 16'(`SERA_WR_CYCLES - 1)) begin
        busy_reg <= 1'b0;
      end else begin
        timer_reg <= timer_reg + 16'h0001;
      end
    end
  end

  // Memory array; a repeated start drains the FIFO without writing.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `SERA_DEPTH; i++) begin
        mem_reg[i] <= `SERA_MEM_RST;
      end
    end else if (fifoPop && busy_reg) begin
      mem_reg[wrAddr_reg] <= fifoData;
    end
  end

  assign fifoPop = fifoValid && (busy_reg || drain_reg);

  // Written bytes wait here; when full, the next data byte is not acknowledged.
  sera_fifo #(
    .W (8),
    .D (`SERA_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .pushValid (dataTake),
    .pushReady (fifoReady),
    .pushData  (shift_reg),
    .popValid  (fifoValid),
    .popReady  (busy_reg || drain_reg),
    .popData   (fifoData)
  );

  // Pin and status outputs straight from flops; the drive level is always low.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end
  assign sdaOe     = sdaOe_reg;
  assign writeBusy = busy_reg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  nack_while_busy_a: assert property (
    (byteDone && kind_reg == KIND_CTRL && busy_reg) |=> (state_reg == ST_IDLE) && !sdaOe_reg)
    else $error("Control byte acknowledged during write cycle.");

  stop_starts_write_a: assert property (
    (stopSeen && wrPending_reg) |=> busy_reg ##1 busy_reg[*8])
    else $error("Stop after write data did not start a write cycle.");

  poll_ack_a: assert property (
    (byteDone && kind_reg == KIND_CTRL && ctrlMatch && !busy_reg) |=> sdaOe_reg && state_reg == ST_ACK)
    else $error("Matching idle control byte was not acknowledged.");

  select_mismatch_a: assert property (
    (byteDone && kind_reg == KIND_CTRL && !ctrlMatch) |=> !sdaOe_reg)
    else $error("Control byte with wrong select bits drew an acknowledge.");

  read_first_bit_a: assert property (
    (state_reg == ST_ACK && sclFall && kind_reg == KIND_CTRL && isRead_reg)
    |=> state_reg == ST_SEND && sdaOe_reg == !$past(rdByte[7]))
    else $error("Read did not begin with the addressed byte.");

  ptr_step_a: assert property (
    loadTx |=> addrPtr_reg == AW'($past(addrPtr_reg) + 1'b1))
    else $error("Address pointer did not step past the byte read.");

  ptr_load_a: assert property (
    addrTake |=> addrPtr_reg == $past(shift_reg[AW-1:0]) ##1 !busy_reg)
    else $error("Word address was not loaded into the pointer.");

  nack_release_a: assert property (
    (state_reg == ST_MACK && sclFall && !mackSeen_reg && !startSeen && !stopSeen)
    |=> state_reg == ST_IDLE && !sdaOe_reg)
    else $error("Slave kept the data line after an unacknowledged byte.");

  seq_next_a: assert property (
    (state_reg == ST_MACK && sclFall && mackSeen_reg && !startSeen && !stopSeen)
    |=> state_reg == ST_SEND && bitCnt_reg == 4'h1)
    else $error("Master acknowledge did not draw the next byte.");
endmodule

//--- logic/sera_cfg.svh
// Purpose: Constants for the two-wire EEPROM read and poll slave.
// Assumes: clk_sys at 200 MHz; the bus clock is far slower.
// Notes: Notes on behaviour follow.
`ifndef SERA_CFG_SVH
`define SERA_CFG_SVH
`define SERA_CLK_NS 5
`define SERA_WR_TIME_NS 2000
`define SERA_WR_CYCLES ((`SERA_WR_TIME_NS + `SERA_CLK_NS - 1) / `SERA_CLK_NS)
`define SERA_CTRL_CODE 4'hA
`define SERA_CODE_MSB 7
`define SERA_CODE_LSB 4
`define SERA_SEL_MSB 3
`define SERA_SEL_LSB 1
`define SERA_RW_BIT 0
`define SERA_ADDR_W 7
`define SERA_DEPTH 128
`define SERA_MEM_RST 8'hFF
`define SERA_FIFO_DEPTH 8
`endif

//--- logic/sera_pkg.sv
// Purpose: Types shared by the EEPROM slave files.
// Assumes: Nothing beyond the constants header.
// Notes: Holds the state and byte kind enumerations.
package sera_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_MACK} sera_state_t;
  typedef enum logic [1:0] {KIND_CTRL, KIND_ADDR, KIND_DATA} sera_kind_t;
endpackage

//--- logic/sera_fifo.sv
// Purpose: Small flip-flop FIFO with valid and ready on both sides.
// Assumes: One clock; depth is a power of two.
// Notes: Full and empty come from an occupancy count.
`timescale 1ns/100ps
module sera_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset.
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  // Filling side.
  input  wire logic         pushValid,
  output logic              pushReady,
  input  wire logic [W-1:0] pushData,
  // Draining side.
  output logic              popValid,
  input  wire logic         popReady,
  output logic [W-1:0]      popData
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  store_reg [D];
  logic [AW-1:0] wrIdx_reg;
  logic [AW-1:0] rdIdx_reg;
  logic [AW:0]   count_reg;
  logic          doPush;
  logic          doPop;

  // Full and empty are honest: a full FIFO refuses the push.
  assign pushReady = (count_reg != D[AW:0]);
  assign popValid  = (count_reg != '0);
  assign popData   = store_reg[rdIdx_reg];
  assign doPush    = pushValid && pushReady;
  assign doPop     = popValid && popReady;

  // Storage is written only on an accepted push.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < D; i++) begin
        store_reg[i] <= '0;
      end
    end else if (doPush) begin
      store_reg[wrIdx_reg] <= pushData;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wrIdx_reg <= '0;
      rdIdx_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doPush) begin
        wrIdx_reg <= wrIdx_reg + 1'b1;
      end
      if (doPop) begin
        rdIdx_reg <= rdIdx_reg + 1'b1;
      end
      if (doPush && !doPop) begin
        count_reg <= count_reg + 1'b1;
      end else if (doPop && !doPush) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

//--- verification/sera_bus_master.sv
// Purpose: Behavioural two-wire bus master that paces the EEPROM slave.
// Assumes: Bus clock of 125 ns made from 25 system clock cycles.
// Notes: The data line is open drain; a released line reads high.
`timescale 1ns/100ps
module sera_bus_master (
  // Bench clock, used only to pace the bus.
  input  wire logic clk_sys,
  // Bus lines driven by the master.
  output logic      sclOut,
  output logic      sdaDrive,
  // Resolved data line level.
  input  wire logic sdaWire
);
  // The bus is idle with both lines high; the clock stands still between frames.
  initial begin
    sclOut = 1'b1;
    sdaDrive = 1'b1;
  end

  // Every change lands on a falling system clock edge, never on the sampling edge.
  task automatic pause(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic start();
    sdaDrive = 1'b1;
    pause(6);
    sclOut = 1'b1;
    pause(6);
    sdaDrive = 1'b0;
    pause(6);
    sclOut = 1'b0;
    pause(6);
  endtask

  task automatic stop();
    sdaDrive = 1'b0;
    pause(6);
    sclOut = 1'b1;
    pause(6);
    sdaDrive = 1'b1;
    pause(12);
  endtask

  // Data changes only while the clock is low; the slave has 30 ns to settle.
  task automatic bitXfer(input logic b, output logic r);
    pause(6);
    sdaDrive = b;
    pause(6);
    sclOut = 1'b1;
    pause(6);
    r = sdaWire;
    pause(7);
    sclOut = 1'b0;
  endtask

  // Sends a byte most significant bit first and reports the acknowledge.
  task automatic wrByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int j = 7; j >= 0; j--) begin
      bitXfer(d[j], r);
    end
    bitXfer(1'b1, r);
    ack = ~r;
  endtask

  // Reads a byte; r is the line level seen during the ninth clock.
  task automatic rdByte(input logic ack, output logic [7:0] d, output logic r);
    for (int j = 7; j >= 0; j--) begin
      bitXfer(1'b1, d[j]);
    end
    bitXfer(~ack, r);
  endtask
endmodule

//--- verification/tb.sv
// Purpose: Self-checking bench for the EEPROM read and polling slave.
// Assumes: A reference memory and pointer mirror what the slave should hold.
// Notes: Random addresses in the write_read test carry a random top bit that the slave must ignore.
`timescale 1ns/100ps
`include "sera_cfg.svh"
`define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end
module tb;
  logic       clk_sys;
  logic       rst_b;
  logic       sclIn;
  logic       masterSda;
  logic       sdaWire;
  logic       sdaOut;
  logic       sdaOe;
  logic       writeBusy;
  logic [2:0] chipSelectInputs;
  logic [2:0] sel;
  logic [7:0] mem [128];
  logic [6:0] ptr;
  logic       ack;
  logic [7:0] wa [4];
  int         fails;
  int         total_checks;

  // Open-drain data line with a pull-up.
  assign sdaWire = (sdaOe ? sdaOut : 1'b1) & masterSda;

  sera_top dut (
    .clk_sys          (clk_sys),
    .rst_b            (rst_b),
    .sclIn            (sclIn),
    .sdaIn            (sdaWire),
    .sdaOut           (sdaOut),
    .sdaOe            (sdaOe),
    .chipSelectInputs (chipSelectInputs),
    .writeBusy        (writeBusy)
  );

  sera_bus_master master (
    .clk_sys  (clk_sys),
    .sclOut   (sclIn),
    .sdaDrive (masterSda),
    .sdaWire  (sdaWire)
  );

  // System clock of 200 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] ctrlByte(input logic [2:0] s, input logic rw);
    return {`SERA_CTRL_CODE, s, rw};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic ctrl(input logic [2:0] s, input logic rw, output logic a);
    master.start();
    master.wrByte(ctrlByte(s, rw), a);
  endtask

  // Reads n bytes, acknowledging all but the last, then stops.
  task automatic readBytes(input int n);
    logic [7:0] d;
    logic       r;
    for (int k = 0; k < n; k++) begin
      master.rdByte(k != n - 1, d, r);
      `CHK("read data", mem[ptr], d)
      ptr = ptr + 7'h01;
    end
    `CHK("line released", 1'b1, r)
    master.stop();
    `CHK("sending ended", 1'b0, sdaOe)
  endtask

  // Address set by a write, aborted by a repeated start, then read.
  task automatic randRead(input logic [7:0] a, input int n);
    ctrl(sel, 1'b0, ack);
    master.wrByte(a, ack);
    `CHK("address ack", 1'b1, ack)
    ctrl(sel, 1'b1, ack);
    `CHK("read ctrl ack", 1'b1, ack)
    ptr = a[6:0];
    readBytes(n);
    `CHK("no write on abort", 1'b0, writeBusy)
  endtask

  // Byte write followed by acknowledge polling.
  task automatic writeByte(input logic [7:0] a, input logic [7:0] d);
    logic a1;
    logic a2;
    ctrl(sel, 1'b0, ack);
    master.wrByte(a, a1);
    master.wrByte(d, a2);
    `CHK("write acks", 3'b111, {ack, a1, a2})
    master.stop();
    mem[a[6:0]] = d;
    `CHK("write started", 1'b1, writeBusy)
    for (int i = 0; i < 40 && writeBusy !== 1'b0 || i == 0; i++) begin
      ctrl(sel, 1'b0, ack);
      if (i == 0) `CHK("busy poll refused", 1'b0, ack)
      if (ack === 1'b1) break;
    end
    if (ack !== 1'b1) begin
      ctrl(sel, 1'b0, ack);
    end
    master.stop();
    `CHK("poll acknowledged", 1'b1, ack)
    if (ack !== 1'b1) summarize();
  endtask

  // Cuts a hang short.
  initial begin
    repeat (100000) @(posedge clk_sys);
    fails++;
    summarize();
  end

  // Main sequence.
  initial begin
    rst_b = 1'b0;
    chipSelectInputs = 3'h0;
    fails = 0;
    total_checks = 0;
    void'($urandom(32'hCCDF));
    for (int i = 0; i < 128; i++) begin
      mem[i] = `SERA_MEM_RST;
    end
    ptr = 7'h00;
    repeat (16) @(negedge clk_sys);
    `CHK("reset drive", 3'b000, {sdaOe, writeBusy, sdaOut})
    rst_b = 1'b1;
    chipSelectInputs = 3'($urandom);
    sel = chipSelectInputs;
    repeat (8) @(negedge clk_sys);
    // Current read straight after reset.
    ctrl(sel, 1'b1, ack);
    `CHK("current read ack", 1'b1, ack)
    readBytes(1);
    $display("test current_read done");
    // A foreign select pattern must be ignored.
    ctrl(sel ^ 3'($urandom_range(1, 7)), 1'b0, ack);
    master.stop();
    `CHK("foreign select", 1'b0, ack)
    $display("test select done");
    // Writes at the top, the bottom and random places, each read back.
    wa = '{8'hFF, 8'h00, 8'($urandom), 8'($urandom)};
    foreach (wa[i]) begin
      writeByte(wa[i], 8'($urandom));
      randRead(wa[i], 1);
      ctrl(sel, 1'b1, ack);
      `CHK("next read ack", 1'b1, ack)
      readBytes(1);
    end
    $display("test write_read done");
    // Data followed by a repeated start must be dropped, so the old byte reads back.
    ptr = 7'($urandom);
    ctrl(sel, 1'b0, ack);
    master.wrByte({1'b0, ptr}, ack);
    master.wrByte(~mem[ptr], ack);
    `CHK("abort data ack", 1'b1, ack)
    randRead({1'b0, ptr}, 1);
    $display("test abort done");
    // Sequential read across the top of memory.
    randRead(8'h7E, 4);
    $display("test sequential done");
    summarize();
  end
endmodule
